// ===== verilog/lcs_command_setup.sv
// Function
// [RULE1] One command register, thirteen operand registers by select; code decodes only codes 00-03 and 0a-0d
// [RULE2] Code with select high, operand low executes
// [RULE3] Busy while executing; new commands ignored
// [RULE4] Host polls busy until zero before writing
// [RULE5] Code 00 selects mode, six data bits
// [RULE6] Mode bits: display, master, cursor, graphic, CG
// [RULE7] Pitch: vertical-1 high nibble, horizontal-1 low bits
// [RULE8] Vertical pitch ignored in graphic mode
// [RULE9] Horizontal pitch only 6, 7 or 8
// [RULE10] Characters per line minus one, even count
// [RULE11] Multiplex count minus one, duty is reciprocal
// [RULE12] Slot order: upper, lower, host phase
// [RULE13] Upper phase lasts 4, 3, 2 clocks; code gives 2, 3, 4 for pitch 6, 7, 8
// [RULE14] Host phase drives cursor address for RAM access
// [RULE15] RAM read captures memory data at phase end
// [RULE16] Reset: display off, slave, pitch 6
// [RULE17] Busy on data bit 7 for status read
// [RULE18] Writes taken at strobe fall; reads while high
// [RULE19] Operand goes to register last code selected
`timescale 1ns/100ps
`default_nettype none

module lcs_command_setup (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // Host bus pins
  input  wire logic        chip_select_low_in,
  input  wire logic        enable_strobe_in,
  input  wire logic        reg_select_in,
  input  wire logic        read_write_in,
  input  wire logic [7:0]  host_data_bus_in,
  output var  logic [7:0]  host_data_bus_out,
  output var  logic        host_data_bus_oe_out,
  // External memory bus
  output var  logic [15:0] memory_address_out,
  input  wire logic [7:0]  memory_data_bus_in,
  output var  logic [7:0]  memory_data_bus_out,
  output var  logic        memory_data_bus_oe_out,
  output var  logic        mem_write_en_low_out,
  output var  logic        mem_chip_en_low_out,
  output var  logic        mem_output_en_out,
  output var  logic [1:0]  phase_out,
  // Display setup
  output var  logic        display_on_out,
  output var  logic        master_out,
  output var  logic [1:0]  cursor_mode_out,
  output var  logic        graphic_mode_out,
  output var  logic        char_pattern_rom_ext_out,
  output var  logic [3:0]  vertical_pitch_out,
  output var  logic [2:0]  horizontal_pitch_out,
  output var  logic [6:0]  chars_per_line_count_out,
  output var  logic [6:0]  multiplex_divisions_out,
  output var  logic        busy_indication_out
);

  typedef struct packed {
    logic [lcs_pkg::PIN_W-1:0] sync1;
    logic [lcs_pkg::PIN_W-1:0] sync2;
    logic [lcs_pkg::PIN_W-1:0] sync3;
    logic [lcs_pkg::PIN_W-1:0] pins;
    logic [7:0]                command_code;
    logic [5:0]                display_mode;
    logic [7:0]                character_pitch;
    logic [7:0]                chars_per_line;
    logic [7:0]                multiplex_count;
    logic                      graphic;
    logic [3:0]                vp_eff;
    logic [15:0]               cursor;
    logic [7:0]                write_data;
    logic [7:0]                read_data;
    logic                      busy;
    logic [2:0]                exec_cnt;
    lcs_pkg::lcs_op_e          op;
    logic                      op_live;
    lcs_pkg::lcs_phase_e       phase;
    logic [2:0]                phase_cnt;
    logic [6:0]                refresh;
    logic [15:0]               addr;
    logic [7:0]                md_out;
    logic                      md_oe;
    logic                      we_low;
    logic                      oe;
    logic [7:0]                db_out;
    logic                      db_oe;
  } lcs_state_s;

  lcs_state_s state;
  lcs_state_s next_state;

  // Combinational next state
  always_comb begin
    logic       e_fall;
    logic       selected;
    logic       e_high;
    logic [7:0] db;
    logic [2:0] hp_code;
    e_fall   = 1'b0;
    selected = 1'b0;
    e_high   = 1'b0;
    db       = 8'h00;
    hp_code  = 3'h0;
    next_state = state;

    // Three-stage pin capture; a bit moves only when stages two and
    // three agree, so a single sampled glitch never reaches the logic
    next_state.sync1 = {memory_data_bus_in, chip_select_low_in,
                        enable_strobe_in, reg_select_in,
                        read_write_in, host_data_bus_in};
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    next_state.pins  = (state.sync2 & state.sync3) |
                       (state.pins & (state.sync2 | state.sync3));

    selected = ~next_state.pins[lcs_pkg::PIN_CS];
    e_high   = next_state.pins[lcs_pkg::PIN_E];
    e_fall   = state.pins[lcs_pkg::PIN_E] & ~e_high &
               ~state.pins[lcs_pkg::PIN_CS];
    db       = state.pins[lcs_pkg::PIN_DB_LSB +: 8];

    // Plain register executions end after a short fixed time
    if (state.exec_cnt != 3'h0) begin
      next_state.exec_cnt = state.exec_cnt - 3'h1;
      if (state.exec_cnt == 3'h1) begin
        next_state.busy = 1'b0;
      end
    end

    // Host write on strobe fall; busy blocks both kinds of write
    if (e_fall && !state.pins[lcs_pkg::PIN_RW] && !state.busy) begin // [RULE18] [RULE3]
      if (state.pins[lcs_pkg::PIN_RS]) begin // [RULE1]
        next_state.command_code = db; // [RULE2]
      end else begin
        next_state.busy     = 1'b1; // [RULE3]
        next_state.exec_cnt = lcs_pkg::EXEC_CYCLES;
        case (state.command_code) // [RULE19] [RULE2]
          lcs_pkg::CMD_MODE: begin
            next_state.display_mode = db[5:0]; // [RULE5]
          end
          lcs_pkg::CMD_PITCH: begin
            // Illegal horizontal codes are dropped whole
            if (db[2:0] >= lcs_pkg::HP_MIN_CODE) begin // [RULE9]
              next_state.character_pitch = {db[7:4], 1'b0, db[2:0]}; // [RULE7]
            end
          end
          lcs_pkg::CMD_CHARS: begin
            // Count minus one kept odd so the count stays even
            next_state.chars_per_line = {1'b0, db[6:1], 1'b1}; // [RULE10]
          end
          lcs_pkg::CMD_MUX: begin
            next_state.multiplex_count = {1'b0, db[6:0]}; // [RULE11]
          end
          lcs_pkg::CMD_CUR_LO: begin
            next_state.cursor[7:0] = db;
          end
          lcs_pkg::CMD_CUR_HI: begin
            next_state.cursor[15:8] = db;
          end
          lcs_pkg::CMD_RAM_WR: begin
            next_state.write_data = db;
            next_state.op         = lcs_pkg::LCS_OP_WRITE;
            next_state.exec_cnt   = 3'h0;
          end
          default: begin
            next_state.exec_cnt = 3'h1;
          end
        endcase
      end
    end

    // Data read in read mode hands out the old byte, fetches the next
    if (e_fall && state.pins[lcs_pkg::PIN_RW] &&
        !state.pins[lcs_pkg::PIN_RS] && !state.busy &&
        state.command_code == lcs_pkg::CMD_RAM_RD) begin
      next_state.busy = 1'b1; // [RULE3]
      next_state.op   = lcs_pkg::LCS_OP_READ;
    end

    // Slot sequencer: upper, lower, host, then again
    if (state.phase_cnt > 3'h1) begin
      next_state.phase_cnt = state.phase_cnt - 3'h1;
    end else begin
      case (state.phase)
        lcs_pkg::LCS_PH_UPPER: begin
          next_state.phase     = lcs_pkg::LCS_PH_LOWER; // [RULE12]
          next_state.phase_cnt = lcs_pkg::T2_CYCLES;
        end
        lcs_pkg::LCS_PH_LOWER: begin
          next_state.phase     = lcs_pkg::LCS_PH_HOST; // [RULE12]
          next_state.phase_cnt = lcs_pkg::T3_CYCLES;
          next_state.op_live   = (next_state.op != lcs_pkg::LCS_OP_NONE);
        end
        default: begin
          // End of host phase completes any live memory access
          if (state.op_live) begin
            // Memory answers our own registered address on this clock,
            // so it is taken directly; the synchroniser would lag a phase
            if (state.op == lcs_pkg::LCS_OP_READ) begin
              next_state.read_data = memory_data_bus_in; // [RULE15]
            end
            next_state.cursor  = state.cursor + 16'h0001;
            next_state.op      = lcs_pkg::LCS_OP_NONE;
            next_state.op_live = 1'b0;
            next_state.busy    = 1'b0;
          end
          hp_code = state.character_pitch[2:0];
          next_state.phase     = lcs_pkg::LCS_PH_UPPER; // [RULE12]
          next_state.phase_cnt = hp_code - lcs_pkg::T1_OFFSET; // [RULE13]
          if (state.refresh >= state.chars_per_line[6:0]) begin
            next_state.refresh = 7'h00;
          end else begin
            next_state.refresh = state.refresh + 7'h01;
          end
        end
      endcase
    end

    // Decoded setup copies, recomputed every cycle
    next_state.graphic =
      next_state.display_mode[lcs_pkg::MODE_GRAPHIC_BIT] &
      ~next_state.display_mode[lcs_pkg::MODE_EXTCG_BIT]; // [RULE6]
    next_state.vp_eff = next_state.graphic ? 4'h0 :
      next_state.character_pitch[lcs_pkg::PITCH_VP_LSB +: 4]; // [RULE8]

    // Memory bus follows the phase it is about to enter
    next_state.md_oe  = 1'b0;
    next_state.we_low = 1'b1;
    next_state.oe     = 1'b1;
    next_state.md_out = 8'h00;
    next_state.addr   = {9'h000, next_state.refresh};
    if (next_state.phase == lcs_pkg::LCS_PH_HOST) begin
      next_state.oe = 1'b0;
      if (next_state.op_live) begin
        next_state.addr = next_state.cursor; // [RULE14]
        if (next_state.op == lcs_pkg::LCS_OP_WRITE) begin
          next_state.md_out = next_state.write_data;
          next_state.md_oe  = 1'b1;
          next_state.we_low = 1'b0;
        end else begin
          next_state.oe = 1'b1;
        end
      end
    end

    // Host read data only while the strobe is high
    next_state.db_oe  = selected && e_high &&
                        next_state.pins[lcs_pkg::PIN_RW]; // [RULE18]
    next_state.db_out = 8'h00;
    if (next_state.db_oe) begin
      if (next_state.pins[lcs_pkg::PIN_RS]) begin
        next_state.db_out[lcs_pkg::BUSY_BIT] = state.busy; // [RULE17]
      end else begin
        next_state.db_out = state.read_data;
      end
    end
  end

  // State register; reset values give display off, slave, pitch 6
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state                 <= '0;
      state.display_mode    <= lcs_pkg::MODE_RST; // [RULE16]
      state.character_pitch <= lcs_pkg::PITCH_RST; // [RULE16]
      state.chars_per_line  <= lcs_pkg::CHARS_RST;
      state.multiplex_count <= lcs_pkg::MUX_RST;
      state.op              <= lcs_pkg::LCS_OP_NONE;
      state.phase           <= lcs_pkg::LCS_PH_UPPER;
      state.phase_cnt       <= 3'h2;
      state.we_low          <= 1'b1;
      state.oe              <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Outputs taken from state flip-flops, except mem_chip_en_low_out, which is tied low
  assign host_data_bus_out        = state.db_out;
  assign host_data_bus_oe_out     = state.db_oe;
  assign memory_address_out       = state.addr;
  assign memory_data_bus_out      = state.md_out;
  assign memory_data_bus_oe_out   = state.md_oe;
  assign mem_write_en_low_out     = state.we_low;
  assign mem_chip_en_low_out      = 1'b0;
  assign mem_output_en_out        = state.oe;
  assign phase_out                = state.phase;
  assign display_on_out           = state.display_mode[lcs_pkg::MODE_DISP_BIT];
  assign master_out               =
    state.display_mode[lcs_pkg::MODE_MASTER_BIT];
  assign cursor_mode_out          =
    state.display_mode[lcs_pkg::MODE_CURSOR_LSB +: 2];
  assign graphic_mode_out         = state.graphic;
  assign char_pattern_rom_ext_out =
    state.display_mode[lcs_pkg::MODE_EXTCG_BIT];
  assign vertical_pitch_out       = state.vp_eff;
  assign horizontal_pitch_out     = state.character_pitch[2:0];
  assign chars_per_line_count_out = state.chars_per_line[6:0];
  assign multiplex_divisions_out  = state.multiplex_count[6:0];
  assign busy_indication_out      = state.busy;

endmodule : lcs_command_setup

`default_nettype wire

// ===== pkg/lcs_pkg.sv
package lcs_pkg;

  // Command codes written with reg_select high
  localparam logic [7:0] CMD_MODE    = 8'h00;
  localparam logic [7:0] CMD_PITCH   = 8'h01;
  localparam logic [7:0] CMD_CHARS   = 8'h02;
  localparam logic [7:0] CMD_MUX     = 8'h03;
  localparam logic [7:0] CMD_CUR_LO  = 8'h0a;
  localparam logic [7:0] CMD_CUR_HI  = 8'h0b;
  localparam logic [7:0] CMD_RAM_WR  = 8'h0c;
  localparam logic [7:0] CMD_RAM_RD  = 8'h0d;

  // Field positions in the display_mode byte
  localparam int MODE_DISP_BIT    = 5;
  localparam int MODE_MASTER_BIT  = 4;
  localparam int MODE_CURSOR_LSB  = 2;
  localparam int MODE_GRAPHIC_BIT = 1;
  localparam int MODE_EXTCG_BIT   = 0;

  // Field positions in the character_pitch byte and host read word
  localparam int PITCH_VP_LSB     = 4;
  localparam int BUSY_BIT         = 7;

  // Values after reset: display off, slave, horizontal pitch 6
  localparam logic [5:0] MODE_RST  = 6'h00;
  localparam logic [7:0] PITCH_RST = 8'h05;
  localparam logic [7:0] CHARS_RST = 8'h01;
  localparam logic [7:0] MUX_RST   = 8'h00;

  // Legal horizontal pitch codes are 5, 6, 7 (pitch 6, 7, 8)
  localparam logic [2:0] HP_MIN_CODE = 3'h5;

  // Phase lengths, upper-phase offset and register execution time in clock cycles
  localparam logic [2:0] T1_OFFSET   = 3'h3;
  localparam logic [2:0] T2_CYCLES   = 3'h2;
  localparam logic [2:0] T3_CYCLES   = 3'h2;
  localparam logic [2:0] EXEC_CYCLES = 3'h2;

  // Layout of the synchronised pin vector
  localparam int PIN_W      = 20;
  localparam int PIN_DB_LSB = 0;
  localparam int PIN_RW     = 8;
  localparam int PIN_RS     = 9;
  localparam int PIN_E      = 10;
  localparam int PIN_CS     = 11;
  localparam int PIN_MD_LSB = 12;

  typedef enum logic [1:0] {
    LCS_PH_UPPER = 2'b00,
    LCS_PH_LOWER = 2'b01,
    LCS_PH_HOST  = 2'b11
  } lcs_phase_e;

  typedef enum logic [1:0] {
    LCS_OP_NONE  = 2'b00,
    LCS_OP_WRITE = 2'b01,
    LCS_OP_READ  = 2'b11
  } lcs_op_e;

endpackage : lcs_pkg

// ===== verif/lcs_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module lcs_mem_model (
  // Clock
  input  wire logic        clock_in,
  // Memory bus from the controller
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wdata_oe_in,
  input  wire logic        we_low_in,
  input  wire logic        rd_en_in,
  // Read data toward the controller
  output var  logic [7:0]  rdata_out
);
  logic [7:0] mem [0:65535];

  // Every location starts with one pattern, so refresh and host reads agree
  initial begin
    rdata_out = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h3c;
    end
  end

  // Toggle when not asked, so a stale byte never passes for fresh data
  always @(posedge clock_in) begin
    if (!we_low_in && wdata_oe_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= rd_en_in ? mem[addr_in] : ~rdata_out;
  end
endmodule : lcs_mem_model

`default_nettype wire

// ===== verif/lcs_checker.sv
`timescale 1ns/100ps
`default_nettype none

module lcs_checker (
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // Observed pins
  input  wire logic       enable_strobe_in,
  input  wire logic       read_write_in,
  input  wire logic       host_data_bus_oe_out,
  input  wire logic       memory_data_bus_oe_out,
  input  wire logic       mem_write_en_low_out,
  input  wire logic [1:0] phase_out,
  input  wire logic       display_on_out,
  input  wire logic       master_out,
  input  wire logic       graphic_mode_out,
  input  wire logic [3:0] vertical_pitch_out,
  input  wire logic [2:0] horizontal_pitch_out,
  input  wire logic [6:0] chars_per_line_count_out,
  input  wire logic [6:0] multiplex_divisions_out,
  input  wire logic       busy_indication_out
);
  logic [2:0] up_cnt;
  logic [2:0] hp_q;
  logic       up_ok;

  // Upper phase length; void if pitch moves mid-phase or after reset
  always_ff @(posedge clock_in) begin
    hp_q <= horizontal_pitch_out;
    if (rst_in) begin
      up_cnt <= 3'h0;
      up_ok  <= 1'b0;
    end else if (phase_out != 2'b00) begin
      up_cnt <= 3'h0;
      up_ok  <= (phase_out == 2'b11);
    end else begin
      up_cnt <= up_cnt + 3'h1;
      if (horizontal_pitch_out != hp_q) up_ok <= 1'b0;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_phase_order: assert property ($changed(phase_out) |-> phase_out ==
    ($past(phase_out) == 2'b00 ? 2'b01 : $past(phase_out) == 2'b01 ? 2'b11
    : 2'b00)) else $error("phase order broken");
  a_upper_len: assert property (phase_out == 2'b01 && up_ok
    && up_cnt != 3'h0 |-> up_cnt == hp_q - 3'h3)
    else $error("upper phase length wrong");
  a_busy_bound: assert property ($rose(busy_indication_out)
    |-> ##[1:24] !busy_indication_out) else $error("busy never clears");
  a_cfg_busy: assert property ($changed(display_on_out)
    || $changed(master_out) || $changed(horizontal_pitch_out)
    || $changed(chars_per_line_count_out) || $changed(graphic_mode_out)
    || $changed(multiplex_divisions_out) |-> busy_indication_out)
    else $error("setup changed without execution");
  a_graphic_vp: assert property (graphic_mode_out
    |-> vertical_pitch_out == 4'h0) else $error("vertical pitch in graphic");
  a_pitch_count: assert property (horizontal_pitch_out >= 3'h5
    && chars_per_line_count_out[0]) else $error("illegal pitch or count");
  a_rst_values: assert property ($fell(rst_in) |-> !display_on_out
    && !master_out && horizontal_pitch_out == 3'h5)
    else $error("bad values after reset");
  a_read_oe: assert property ($rose(host_data_bus_oe_out)
    |-> $past(enable_strobe_in, 2) && $past(read_write_in, 2))
    else $error("host bus driven outside a read");
  a_we_host: assert property ($fell(mem_write_en_low_out) |->
    phase_out == 2'b11 && memory_data_bus_oe_out ##1 !mem_write_en_low_out
    ##1 mem_write_en_low_out) else $error("write strobe outside host phase");

  c_graphic: cover property (graphic_mode_out);
  c_ram_write: cover property ($fell(mem_write_en_low_out));
  c_busy: cover property ($rose(busy_indication_out));
  c_upper4: cover property (phase_out == 2'b01 && up_ok && up_cnt == 3'h4);
endmodule : lcs_checker

bind lcs_command_setup lcs_checker u_chk (.clock_in, .rst_in,
  .enable_strobe_in, .read_write_in, .host_data_bus_oe_out,
  .memory_data_bus_oe_out, .mem_write_en_low_out, .phase_out,
  .display_on_out, .master_out, .graphic_mode_out, .vertical_pitch_out,
  .horizontal_pitch_out, .chars_per_line_count_out,
  .multiplex_divisions_out, .busy_indication_out);

`default_nettype wire

// ===== verif/lcs_command_setup_tb.sv
`timescale 1ns/100ps
`default_nettype none

module lcs_command_setup_tb;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        chip_select_low_in = 1'b0;
  logic        enable_strobe_in = 1'b0;
  logic        reg_select_in = 1'b0;
  logic        read_write_in = 1'b1;
  logic [7:0]  host_data_bus_in = 8'h00;
  logic [7:0]  host_data_bus_out, memory_data_bus_in, memory_data_bus_out;
  logic [15:0] memory_address_out;
  logic        memory_data_bus_oe_out, mem_write_en_low_out;
  logic        mem_output_en_out, display_on_out, master_out;
  logic        graphic_mode_out, char_pattern_rom_ext_out;
  logic        busy_indication_out;
  logic [1:0]  cursor_mode_out;
  logic [3:0]  vertical_pitch_out;
  logic [2:0]  horizontal_pitch_out;
  logic [6:0]  chars_per_line_count_out, multiplex_divisions_out;
  logic [7:0]  x;
  int          fails = 0;
  int          check_count = 0;
  localparam logic [7:0] MODE_OP [6] = '{8'hf0, 8'hf4, 8'hf8, 8'hfc,
                                         8'h23, 8'h22};
  localparam logic [7:0] MODE_EX [6] = '{8'h30, 8'h34, 8'h38, 8'h3c,
                                         8'h21, 8'h22};
  localparam logic [7:0] HN_OP [4] = '{8'h7f, 8'h02, 8'h81, 8'h00};
  localparam logic [7:0] HN_EX [4] = '{8'h7f, 8'h03, 8'h01, 8'h01};

  always #5 clock_in = ~clock_in;

  lcs_command_setup dut (.clock_in, .rst_in, .chip_select_low_in,
    .enable_strobe_in, .reg_select_in, .read_write_in, .host_data_bus_in,
    .host_data_bus_out, .host_data_bus_oe_out(), .memory_address_out,
    .memory_data_bus_in, .memory_data_bus_out, .memory_data_bus_oe_out,
    .mem_write_en_low_out, .mem_chip_en_low_out(), .mem_output_en_out,
    .phase_out(), .display_on_out, .master_out, .cursor_mode_out,
    .graphic_mode_out, .char_pattern_rom_ext_out, .vertical_pitch_out,
    .horizontal_pitch_out, .chars_per_line_count_out,
    .multiplex_divisions_out, .busy_indication_out);

  lcs_mem_model u_mem (.clock_in, .addr_in(memory_address_out),
    .wdata_in(memory_data_bus_out), .wdata_oe_in(memory_data_bus_oe_out),
    .we_low_in(mem_write_en_low_out), .rd_en_in(mem_output_en_out),
    .rdata_out(memory_data_bus_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Strobe high and low 8 cycles each, well above the filter's needs
  task automatic wr(input logic s, input logic [7:0] d);
    reg_select_in = s;
    read_write_in = 1'b0;
    host_data_bus_in = d;
    enable_strobe_in = 1'b1;
    repeat (8) @(negedge clock_in);
    enable_strobe_in = 1'b0;
    repeat (8) @(negedge clock_in);
  endtask : wr

  task automatic rd(input logic s, output logic [7:0] d);
    reg_select_in = s;
    read_write_in = 1'b1;
    enable_strobe_in = 1'b1;
    repeat (8) @(negedge clock_in);
    d = host_data_bus_out;
    enable_strobe_in = 1'b0;
    repeat (8) @(negedge clock_in);
  endtask : rd

  // Poll status until free; a stuck flag ends the run
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(1'b1, x);
      n++;
    end while (x[7] === 1'b1 && n < 20);
    chk(x, 8'h00);
    if (x !== 8'h00) results;
  endtask : idle

  task automatic setreg(input logic [7:0] code, input logic [7:0] d);
    wr(1'b1, code);
    wr(1'b0, d);
    idle;
  endtask : setreg

  initial begin
    repeat (12) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    chk({3'h0, display_on_out, master_out, horizontal_pitch_out}, 8'h05);
    idle;
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      setreg(8'h00, MODE_OP[i]);
      chk({2'h0, display_on_out, master_out, cursor_mode_out,
           graphic_mode_out, char_pattern_rom_ext_out}, MODE_EX[i]);
    end
    $display("mode test done");
    for (int h = 5; h < 8; h++) begin
      setreg(8'h01, 8'h90 | 8'(h));
      chk({vertical_pitch_out, 1'b0, horizontal_pitch_out}, 8'(h));
    end
    setreg(8'h00, 8'h20);
    setreg(8'h01, 8'h9e);
    chk({vertical_pitch_out, 1'b0, horizontal_pitch_out}, 8'h96);
    setreg(8'h01, 8'h33);
    chk({vertical_pitch_out, 1'b0, horizontal_pitch_out}, 8'h96);
    $display("pitch test done");
    for (int i = 0; i < 4; i++) begin
      setreg(8'h02, HN_OP[i]);
      chk({1'b0, chars_per_line_count_out}, HN_EX[i]);
    end
    setreg(8'h03, 8'hff);
    chk({1'b0, multiplex_divisions_out}, 8'h7f);
    wr(1'b0, 8'h00);
    idle;
    chk({1'b0, multiplex_divisions_out}, 8'h00);
    chk({1'b0, chars_per_line_count_out}, 8'h01);
    $display("count test done");
    setreg(8'h0a, 8'h23);
    setreg(8'h0b, 8'h01);
    setreg(8'h0c, 8'h5a);
    wr(1'b0, 8'ha5);
    idle;
    chk(u_mem.mem[16'h0123], 8'h5a);
    chk(u_mem.mem[16'h0124], 8'ha5);
    $display("memory write test done");
    // Read back the bytes just written; first read is the dummy one
    setreg(8'h0a, 8'h23);
    setreg(8'h0b, 8'h01);
    wr(1'b1, 8'h0d);
    rd(1'b0, x);
    idle;
    rd(1'b0, x);
    chk(x, 8'h5a);
    idle;
    rd(1'b0, x);
    chk(x, 8'ha5);
    idle;
    $display("memory read test done");
    results;
  end
endmodule : lcs_command_setup_tb

`default_nettype wire
